// ===== hdl/csu_pkg.sv
package csu_pkg;
    localparam logic [6:0] OP_LESS    = 7'h30;
    localparam logic [6:0] OP_EQUAL   = 7'h31;
    localparam logic [6:0] OP_GREATER = 7'h32;
    localparam int         OP_MSB     = 15;
    localparam int         OP_LSB     = 9;
    localparam int         ABIT_POS   = 8;
    localparam logic [7:0] IDX_LIMIT  = 8'h5F;
    localparam logic [1:0] QPH_RESET  = 2'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        CSU_Q1,
        CSU_Q2,
        CSU_Q3,
        CSU_Q4
    } csu_phase_e;

    typedef enum logic [1:0] {
        CSU_EXEC,
        CSU_SKIP1,
        CSU_SKIP2
    } csu_mode_e;
endpackage

// ===== hdl/csu_cmp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface csu_cmp_if;
    logic [7:0] fileByte;
    logic [7:0] workByte;
    logic       isGreater;
    logic       isLess;
    logic       isEqual;
    modport core (output fileByte, output workByte, input isGreater, input isLess, input isEqual);
    modport cmp  (input fileByte, input workByte, output isGreater, output isLess, output isEqual);
endinterface
`default_nettype wire

// ===== hdl/csu_compare.sv
`timescale 1ns/100ps
`default_nettype none
module csu_compare (
    csu_cmp_if.cmp cmpBus
);
    logic [8:0] diff;

    // Unsigned subtract, borrow gives less
    assign diff             = {1'b0, cmpBus.fileByte} - {1'b0, cmpBus.workByte};
    assign cmpBus.isLess    = diff[8];
    assign cmpBus.isEqual   = (diff[7:0] == 8'h00);
    assign cmpBus.isGreater = !diff[8] && (diff[7:0] != 8'h00);
endmodule
`default_nettype wire

// ===== hdl/compare_skip_unit.sv
`timescale 1ns/100ps
`default_nettype none
module compare_skip_unit #(
    parameter int DATA_W = 8
) (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        instrValid,
    input  wire logic [15:0] instrWord,
    input  wire logic        nextTwoWord,
    input  wire logic        extendedSet,
    input  wire logic [7:0]  workingRegister,
    input  wire logic [3:0]  bankSelectRegister,
    input  wire logic [7:0]  readData,
    output logic             busy,
    output logic [1:0]       quadPhase,
    output logic             readEnable,
    output logic [11:0]      readAddr,
    output logic             indexedMode,
    output logic [7:0]       indexOffset,
    output logic             discardNext,
    output logic             noOperation,
    output logic             writeEnable,
    output logic             flagsWrite,
    output logic             doneStrobe,
    output logic [1:0]       cycleCount
);
    initial begin
        if (DATA_W != 8) begin
            $error("compare_skip_unit supports only 8-bit data");
        end
    end

    typedef struct packed {
        logic                 rstMeta;
        logic                 rstSync;
        csu_pkg::csu_phase_e  phase;
        csu_pkg::csu_mode_e   mode;
        logic                 active;
        logic [1:0]           kind;
        logic                 accessBit;
        logic [7:0]           fileAddr;
        logic                 twoWord;
        logic [7:0]           fileByte;
        logic                 skip;
        logic                 discard;
        logic                 done;
        logic [1:0]           cycles;
        logic [1:0]           cycAcc;
    } csu_state_s;

    csu_state_s s_q;
    csu_state_s s_d;
    csu_cmp_if  cmpBus ();

    logic [6:0] opField;
    logic       hit;

    assign opField = instrWord[csu_pkg::OP_MSB:csu_pkg::OP_LSB];
    assign hit = (opField == csu_pkg::OP_GREATER) || (opField == csu_pkg::OP_LESS) ||
                 (opField == csu_pkg::OP_EQUAL);

    assign cmpBus.fileByte = s_q.fileByte;
    assign cmpBus.workByte = workingRegister;

    csu_compare u_cmp (
        .cmpBus (cmpBus)
    );

    always_comb begin
        s_d         = s_q;
        s_d.rstMeta = 1'b1;
        s_d.rstSync = s_q.rstMeta;
        s_d.done    = 1'b0;
        s_d.discard = 1'b0;
        if (s_q.rstSync) begin
            s_d.phase = csu_pkg::csu_phase_e'(s_q.phase + 2'd1);
            unique case (s_q.mode)
                csu_pkg::CSU_EXEC: begin
                    unique case (s_q.phase)
                        csu_pkg::CSU_Q1: begin
                            s_d.active = instrValid && hit;
                            s_d.kind   = opField[1:0];
                            s_d.accessBit = instrWord[csu_pkg::ABIT_POS];
                            s_d.fileAddr  = instrWord[7:0];
                            s_d.twoWord   = nextTwoWord;
                        end
                        csu_pkg::CSU_Q2: begin
                            s_d.fileByte = readData;
                        end
                        csu_pkg::CSU_Q3: begin
                            unique case (s_q.kind)
                                2'd2:    s_d.skip = s_q.active && cmpBus.isGreater;
                                2'd0:    s_d.skip = s_q.active && cmpBus.isLess;
                                default: s_d.skip = s_q.active && cmpBus.isEqual;
                            endcase
                        end
                        csu_pkg::CSU_Q4: begin
                            s_d.cycAcc = 2'd1;
                            if (s_q.skip) begin
                                s_d.discard = 1'b1;
                                s_d.mode    = csu_pkg::CSU_SKIP1;
                            end else if (s_q.active) begin
                                s_d.done   = 1'b1;
                                s_d.cycles = 2'd1;
                                s_d.active = 1'b0;
                            end
                        end
                    endcase
                end
                csu_pkg::CSU_SKIP1: begin
                    if (s_q.phase == csu_pkg::CSU_Q4) begin
                        s_d.cycAcc = 2'd2;
                        if (s_q.twoWord) begin
                            s_d.mode = csu_pkg::CSU_SKIP2;
                        end else begin
                            s_d.mode   = csu_pkg::CSU_EXEC;
                            s_d.done   = 1'b1;
                            s_d.cycles = 2'd2;
                            s_d.active = 1'b0;
                            s_d.skip   = 1'b0;
                        end
                    end
                end
                csu_pkg::CSU_SKIP2: begin
                    if (s_q.phase == csu_pkg::CSU_Q4) begin
                        s_d.cycAcc = 2'd3;
                        s_d.mode   = csu_pkg::CSU_EXEC;
                        s_d.done   = 1'b1;
                        s_d.cycles = 2'd3;
                        s_d.active = 1'b0;
                        s_d.skip   = 1'b0;
                    end
                end
                default: s_d.mode = csu_pkg::CSU_EXEC;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    logic inExec;
    assign inExec = (s_q.mode == csu_pkg::CSU_EXEC);

    assign busy        = s_q.active || !inExec;
    assign quadPhase   = s_q.phase;
    assign readEnable  = inExec && s_q.active && (s_q.phase == csu_pkg::CSU_Q2);
    assign indexedMode = extendedSet && !s_q.accessBit && (s_q.fileAddr <= csu_pkg::IDX_LIMIT);
    assign indexOffset = s_q.fileAddr;
    assign readAddr    = s_q.accessBit ? {bankSelectRegister, s_q.fileAddr} :
                         (s_q.fileAddr[7] ? {4'hF, s_q.fileAddr} : {4'h0, s_q.fileAddr});
    assign discardNext = s_q.discard;
    assign noOperation = !inExec;
    assign writeEnable = 1'b0;
    assign flagsWrite  = 1'b0;
    assign doneStrobe  = s_q.done;
    assign cycleCount  = s_q.cycles;
endmodule
`default_nettype wire

// ===== tb/csu_props.sv
`timescale 1ns/100ps
`default_nettype none
module csu_props (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic [15:0] instrWord,
    input wire logic        extendedSet,
    input wire logic [3:0]  bankSelectRegister,
    input wire logic [1:0]  quadPhase,
    input wire logic        busy,
    input wire logic [7:0]  indexOffset,
    input wire logic        readEnable,
    input wire logic [11:0] readAddr,
    input wire logic        indexedMode,
    input wire logic        discardNext,
    input wire logic        noOperation,
    input wire logic        writeEnable,
    input wire logic        flagsWrite,
    input wire logic        doneStrobe,
    input wire logic [1:0]  cycleCount
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_two; ##4 (doneStrobe && cycleCount == 2'h2); endsequence
    sequence s_three; ##8 (doneStrobe && cycleCount == 2'h3); endsequence
    property p_q2; readEnable |-> quadPhase == 2'h1; endproperty
    property p_bank; readEnable && $past(instrWord[8]) |-> readAddr == {bankSelectRegister, $past(instrWord[7:0])};
    endproperty
    property p_acc; readEnable && !$past(instrWord[8]) |-> readAddr == {{4{$past(instrWord[7])}}, $past(instrWord[7:0])};
    endproperty
    property p_idx; readEnable |-> indexedMode == (extendedSet && !$past(instrWord[8]) && $past(instrWord[7:0]) <= 8'h5F);
    endproperty
    property p_keep; !writeEnable && !flagsWrite; endproperty
    property p_off; readEnable |-> indexOffset == $past(instrWord[7:0]); endproperty
    property p_busy; (readEnable || noOperation) |-> busy; endproperty
    property p_done; readEnable |-> ##3 ((doneStrobe && cycleCount == 2'h1) || discardNext); endproperty
    property p_nop; discardNext |-> noOperation [*4]; endproperty
    property p_skip; discardNext |-> s_two or s_three; endproperty
    a_q2: assert property (p_q2) else $error("read outside Q2");
    a_bank: assert property (p_bank) else $error("bad banked address");
    a_acc: assert property (p_acc) else $error("bad access address");
    a_idx: assert property (p_idx) else $error("bad indexed mode");
    a_keep: assert property (p_keep) else $error("write seen");
    a_off: assert property (p_off) else $error("bad literal offset");
    a_busy: assert property (p_busy) else $error("busy low in instruction");
    a_done: assert property (p_done) else $error("bad one cycle end");
    a_nop: assert property (p_nop) else $error("short no-op");
    a_skip: assert property (p_skip) else $error("bad skip length");
endmodule
bind compare_skip_unit csu_props u_csu_props (.*);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        sys_clk = 1'b0, arst_n = 1'b0, instrValid = 1'b0, nextTwoWord = 1'b0, extendedSet = 1'b1;
    logic [15:0] instrWord = 16'h0000;
    logic [7:0]  workingRegister = 8'h00, readData = 8'h00, indexOffset;
    logic [3:0]  bankSelectRegister = 4'h0;
    logic [11:0] readAddr;
    logic [1:0]  quadPhase, cycleCount, expQ[$];
    logic        busy, readEnable, indexedMode, discardNext, noOperation, writeEnable, flagsWrite, doneStrobe;
    logic [31:0] seed = 32'h0000_19d9;
    int          errCount = 0, nTests = 0, tmo = 0;
    logic [6:0]  opTab[3] = '{csu_pkg::OP_LESS, csu_pkg::OP_EQUAL, csu_pkg::OP_GREATER};
    compare_skip_unit u_compare_skip_unit (.*);
    initial forever #2 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic conclude();
        $display("tests %0d errors %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic issue(input logic [6:0] op, input logic a, input logic [7:0] f, w, rd, input logic two);
        logic skip;
        int   n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (quadPhase !== 2'h0 && n < 8);
        instrWord <= {op, a, f};
        workingRegister <= w;
        readData <= rd;
        nextTwoWord <= two;
        skip = op == csu_pkg::OP_EQUAL ? rd == w : op == csu_pkg::OP_GREATER ? rd > w : rd < w;
        n = op inside {opTab} ? (skip ? (two ? 3 : 2) : 1) : 0;
        if (n > 0) expQ.push_back(2'(n));
        repeat (n > 0 ? 4 * n - 1 : 3) @(negedge sys_clk);
    endtask
    always @(negedge sys_clk) begin
        if (doneStrobe === 1'b1) begin
            chk(cycleCount, expQ.size() > 0 ? expQ.pop_front() : 2'h0);
        end
    end
    always @(posedge sys_clk) begin
        tmo <= tmo + 1;
        if (tmo == 5000) begin
            errCount++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(negedge sys_clk);
        instrValid <= 1'b1;
        for (int i = 0; i < 18; i++) issue(opTab[i % 3], i[0], 8'h5F + 8'(i % 2), 8'h7F, 8'(i / 3 % 3 * 127), i >= 9);
        // Unmatched code must stay silent
        issue(7'h33, 1'b0, 8'h10, 8'h00, 8'h01, 1'b0);
        $display("test directed done");
        for (int i = 0; i < 60; i++) begin
            seed = xs(seed);
            extendedSet <= seed[0];
            bankSelectRegister <= seed[4:1];
            issue(opTab[seed[6:5] % 3], seed[7], seed[15:8], seed[23:16], seed[2] ? seed[23:16] : seed[31:24], seed[3]);
        end
        instrValid <= 1'b0;
        repeat (16) @(negedge sys_clk);
        chk(2'(expQ.size()), 2'h0);
        $display("test random done");
        conclude();
    end
endmodule
`default_nettype wire
